/* File: core/buck1_op_pkg.sv */
// Constants for the first buck converter operating-voltage register.
// Assumes an 8-bit register port; offsets are byte addresses on that port.
package buck1_op_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] BUCK1_OPERATING_SETTING_ADDR = 8'h04;  // Register offset
  localparam int         REG_W                        = 8;      // Register width

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CODE_LSB   = 0;  // Voltage code low bit
  localparam int CODE_MSB   = 5;  // Voltage code high bit
  localparam int CODE_W     = 6;  // Voltage code width
  localparam int SELECT_BIT = 6;  // Output source select bit
  localparam int RSVD_BIT   = 7;  // Reserved bit, reads zero
  localparam int RANGE_W    = 2;  // Range field width

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       SELECT_RESET = 1'b0;   // Register is the source after reset while the strap is high
  localparam logic [7:0] RDATA_IDLE   = 8'h00;  // Read data for unmapped offsets

  // Source of the converter's voltage code
  typedef enum logic {
    SRC_OPERATING,
    SRC_SCALED
  } buck1_src_t;

endpackage : buck1_op_pkg

/* File: core/buck1_source_mux.sv */
// Chooses which register drives the first buck converter's voltage code.
// Assumes all inputs are synchronous levels; purely combinational.
`timescale 1ns/1ns
`default_nettype none

module buck1_source_mux (
  input  wire logic                           i_output_source_select,
  input  wire logic                           i_config_strap_b,
  input  wire logic                           i_buck1_source_pin,
  input  wire logic [buck1_op_pkg::CODE_W-1:0] i_operating_code,
  input  wire logic [buck1_op_pkg::CODE_W-1:0] i_scaled_code,
  output logic      [buck1_op_pkg::CODE_W-1:0] o_selected_code,
  output buck1_op_pkg::buck1_src_t            o_source
);
  import buck1_op_pkg::*;

  // ----------------------------------------------------------------
  // Source decision
  // ----------------------------------------------------------------
  // The select bit wins when set; the pin only acts with a low strap
  always_comb begin
    o_source = SRC_OPERATING;
    if (i_output_source_select) begin
      o_source = SRC_SCALED;
    end else if (!i_config_strap_b) begin
      o_source = i_buck1_source_pin ? SRC_SCALED : SRC_OPERATING;
    end else begin
      o_source = SRC_OPERATING;
    end
  end

  // Code follows the chosen source
  always_comb begin
    o_selected_code = (o_source == SRC_SCALED) ? i_scaled_code : i_operating_code;
  end

endmodule : buck1_source_mux

`default_nettype wire

/* File: core/buck1_voltage_select_reg.sv */
// Operating-voltage register of the first buck converter with source selection.
// Assumes a synchronous byte register port, a synchronous power-on reset and
// that the scaled register, range field and one-time-programmed default live
// elsewhere and arrive as steady levels.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Select bit zero, strap high: voltage from this register
// - Select bit one: voltage from scaled register
// - Strap low, select zero: pin picks source
// - Code interpreted with separate two-bit range
// - Power request low restores default code
// - Power-on reset restores whole register
module buck1_voltage_select_reg #(
  parameter int ADDR_W = 8  // Width of the register address port
) (
  input  wire logic                             i_core_clk,
  input  wire logic                             i_rst,
  input  wire logic                             i_clk_en,
  // Register port
  input  wire logic [ADDR_W-1:0]                i_reg_addr,
  input  wire logic                             i_reg_wr,
  input  wire logic                             i_reg_rd,
  input  wire logic [buck1_op_pkg::REG_W-1:0]   i_reg_wdata,
  output logic      [buck1_op_pkg::REG_W-1:0]   o_reg_rdata,
  // Device pins and neighbouring registers
  input  wire logic                             i_config_strap_b,
  input  wire logic                             i_buck1_source_pin,
  input  wire logic                             i_power_request_pin,
  input  wire logic [buck1_op_pkg::CODE_W-1:0]  i_otp_default_code,
  input  wire logic [buck1_op_pkg::CODE_W-1:0]  i_buck1_scaled_setting,
  input  wire logic [buck1_op_pkg::RANGE_W-1:0] i_buck1_range,
  // Converter control
  output logic      [buck1_op_pkg::CODE_W-1:0]  o_buck1_voltage_code,
  output logic      [buck1_op_pkg::RANGE_W-1:0] o_buck1_range,
  output logic                                  o_buck1_uses_scaled
);
  import buck1_op_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The register offset must be reachable on the address port
  if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr_w
    $error("ADDR_W must lie between 3 and 8");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [CODE_W-1:0]  code_reg;        // Stored voltage code
  logic               select_reg;      // Output source select bit
  logic [CODE_W-1:0]  mux_code;        // Code chosen by the source mux
  buck1_src_t         mux_src;         // Source chosen by the source mux
  logic               hit;             // Access addresses this register
  logic               wr_hit;          // Write to this register

  // Address match, shared by reads and writes
  function automatic logic addr_match(input logic [ADDR_W-1:0] addr);
    addr_match = (addr == ADDR_W'(BUCK1_OPERATING_SETTING_ADDR));
  endfunction : addr_match

  assign hit    = addr_match(i_reg_addr);
  assign wr_hit = i_reg_wr && hit;

  // ----------------------------------------------------------------
  // Voltage code field
  // ----------------------------------------------------------------
  // Default comes from programmed configuration, so variants differ.
  // Power request low wins over a write in the same cycle, so software
  // cannot move the stored code while power request holds it at its default.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      code_reg <= i_otp_default_code;
    end else if (i_clk_en) begin
      if (!i_power_request_pin) begin
        code_reg <= i_otp_default_code;
      end else if (wr_hit) begin
        code_reg <= i_reg_wdata[CODE_MSB:CODE_LSB];
      end
    end
  end

  // ----------------------------------------------------------------
  // Source select bit
  // ----------------------------------------------------------------
  // Not touched by power request; only reset and writes change it
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      select_reg <= SELECT_RESET;
    end else if (i_clk_en && wr_hit) begin
      select_reg <= i_reg_wdata[SELECT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Registered read data; unmapped offsets answer zero
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_reg_rdata <= RDATA_IDLE;
    end else if (i_clk_en) begin
      if (i_reg_rd && hit) begin
        o_reg_rdata <= {1'b0, select_reg, code_reg};
      end else begin
        o_reg_rdata <= RDATA_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  // The strap is trusted as given: with a low strap and the bit set,
  // the bit still wins, which is why software must keep it clear
  buck1_source_mux u_mux (
    .i_output_source_select (select_reg),
    .i_config_strap_b       (i_config_strap_b),
    .i_buck1_source_pin     (i_buck1_source_pin),
    .i_operating_code       (code_reg),
    .i_scaled_code          (i_buck1_scaled_setting),
    .o_selected_code        (mux_code),
    .o_source               (mux_src)
  );

  // ----------------------------------------------------------------
  // Converter outputs
  // ----------------------------------------------------------------
  // Code and range are registered together so the converter never
  // sees a code decoded against a stale range
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_buck1_voltage_code <= '0;
      o_buck1_range        <= '0;
      o_buck1_uses_scaled  <= 1'b0;
    end else if (i_clk_en) begin
      o_buck1_voltage_code <= mux_code;
      o_buck1_range        <= i_buck1_range;
      o_buck1_uses_scaled  <= (mux_src == SRC_SCALED);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_default_code: assert property (
    @(posedge i_core_clk) i_rst |=> (code_reg == $past(i_otp_default_code)) && !select_reg)
    else $error("reset did not restore the register");

  a_power_req_default: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !i_power_request_pin) |=> code_reg == $past(i_otp_default_code))
    else $error("power request low did not restore code");

  a_reserved_reads_zero: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_reg_rdata[RSVD_BIT] == 1'b0)
    else $error("reserved bit read nonzero");

  a_write_then_read: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && wr_hit && i_power_request_pin) ##1
    (i_clk_en && i_reg_rd && hit && !i_reg_wr && i_power_request_pin)
    |=> o_reg_rdata[SELECT_BIT:0] == $past(i_reg_wdata[SELECT_BIT:0], 2))
    else $error("written value not read back");

  a_src_operating: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !select_reg && i_config_strap_b)
    |=> o_buck1_voltage_code == $past(code_reg) && !o_buck1_uses_scaled)
    else $error("operating code not driven");

  a_src_scaled: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && select_reg)
    |=> o_buck1_voltage_code == $past(i_buck1_scaled_setting) && o_buck1_uses_scaled)
    else $error("scaled code not driven");

  a_pin_controls_src: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !select_reg && !i_config_strap_b)
    |=> o_buck1_uses_scaled == $past(i_buck1_source_pin))
    else $error("source pin ignored with strap low");

  a_range_follows: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_clk_en |=> o_buck1_range == $past(i_buck1_range))
    else $error("range not passed with code");

  a_freeze_when_idle: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !i_clk_en |=> $stable(code_reg) && $stable(select_reg) && $stable(o_buck1_voltage_code))
    else $error("state moved with clock enable low");

  a_reset_outputs_zero: assert property (
    @(posedge i_core_clk)
    i_rst |=> (o_buck1_voltage_code == '0) && !o_buck1_uses_scaled && (o_reg_rdata == RDATA_IDLE))
    else $error("converter outputs not cleared by reset");

  a_code_write_lands: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && wr_hit && i_power_request_pin)
    |=> code_reg == $past(i_reg_wdata[CODE_MSB:CODE_LSB]))
    else $error("voltage code write lost");

  a_select_write_lands: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && wr_hit) |=> select_reg == $past(i_reg_wdata[SELECT_BIT]))
    else $error("source select write lost");

  a_unmapped_reads_zero: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (i_clk_en && !(i_reg_rd && hit)) |=> o_reg_rdata == RDATA_IDLE)
    else $error("read data not idle without a read hit");

endmodule : buck1_voltage_select_reg

`default_nettype wire

/* File: sim/buck1_host_model.sv */
// Host model that reaches the buck1 register port over the byte strobe port.
// Assumes it is called just after a rising edge and owns the port.
`timescale 1ns/1ns
`default_nettype none

module buck1_host_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_config_strap_b,
  input  wire logic [7:0] i_reg_rdata,
  output logic      [7:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_wdata
);
  // ----------------------------------------------------------------
  // Port access
  // ----------------------------------------------------------------
  // Idle port until the first access, so no strobe is unknown
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // One byte write, held over one edge, then the bus shows junk
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    if (!i_config_strap_b) d[6] = 1'b0;
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_wr    = 1'b1;
    @(posedge i_core_clk) #5;
    o_reg_wr    = 1'b0;
    o_reg_wdata = ~d;
  endtask : write_reg

  // One byte read; data is taken just after the edge that takes the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    o_reg_addr = a;
    o_reg_rd   = 1'b1;
    @(posedge i_core_clk) #5;
    o_reg_rd   = 1'b0;
    o_reg_addr = ~a;
    d          = i_reg_rdata;
  endtask : read_reg
endmodule : buck1_host_model

`default_nettype wire

/* File: sim/buck1_voltage_select_reg_tb_top.sv */
// Self-checking bench for the buck1 operating-voltage register.
// Assumes the host model drives the register port; seed fixed for replay.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

module buck1_voltage_select_reg_tb_top;
  import buck1_op_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, clk_en = 1'b1;  // Clock, reset, enable
  logic       strap = 1'b1, pin = 1'b0, pwr = 1'b1;   // Device pins
  logic [5:0] otp = 6'h1c, scaled = 6'h20;            // Default and scaled codes
  logic [1:0] rng = 2'h1;                              // Range field
  logic [7:0] addr, wdata, rdata, q, d, a;             // Register port
  logic       wr, rd, uses, en, m_sel;                 // Strobes and model select
  logic [5:0] code, m_code;                            // Output and model code
  logic [1:0] orng;                                    // Range output
  int         miscompares = 0, checked = 0, cycles = 0;

  buck1_voltage_select_reg dut_u (.i_core_clk(clk), .i_rst(rst), .i_clk_en(clk_en),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_config_strap_b(strap), .i_buck1_source_pin(pin),
    .i_power_request_pin(pwr), .i_otp_default_code(otp), .i_buck1_scaled_setting(scaled),
    .i_buck1_range(rng), .o_buck1_voltage_code(code), .o_buck1_range(orng),
    .o_buck1_uses_scaled(uses));
  buck1_host_model host_u (.i_core_clk(clk), .i_config_strap_b(strap), .i_reg_rdata(rdata),
    .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata));

  // ----------------------------------------------------------------
  // Clock, hang guard and verdict
  // ----------------------------------------------------------------
  initial forever #20 clk = ~clk;
  // Run needs about 140 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // Scaled code wins on select bit, or on the pin while the strap is low
  function automatic logic want_scaled();
    return m_sel || (!strap && pin);
  endfunction : want_scaled

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hdb55));
    m_sel  = 1'b0;
    m_code = otp;
    repeat (4) @(posedge clk);
    #5;
    `CHK(code, 6'h00)
    repeat (4) @(posedge clk);
    #5;
    rst = 1'b0;
    host_u.read_reg(8'h04, q);
    `CHK(q, {2'b00, otp})
    // Idle edges keep back-to-back calls from driving a signal twice at once
    @(posedge clk) #5;
    // All-ones write to an unmapped offset, then reserved bit ignored on a write to 04
    host_u.write_reg(8'hff, 8'hff);
    @(posedge clk) #5;
    host_u.write_reg(8'h04, 8'hbf);
    host_u.read_reg(8'h04, q);
    `CHK(q, 8'h3f)
    m_code = 6'h3f;
    repeat (40) begin
      // strap stays high while select set
      strap  = 1'($urandom) | m_sel;
      pin    = 1'($urandom);
      pwr    = ($urandom % 4) != 0;
      otp    = 6'($urandom);
      scaled = 6'($urandom);
      rng    = 2'($urandom);
      @(posedge clk) #5;
      if (!pwr) m_code = otp;
      a  = (($urandom % 4) == 0) ? 8'h03 : 8'h04;
      d  = 8'($urandom);
      en = ($urandom % 8) != 0;
      if (!strap) d[6] = 1'b0;
      clk_en = en;
      host_u.write_reg(a, d);
      clk_en = 1'b1;
      // Frozen edge or foreign offset leaves the register alone
      if (en && a == 8'h04) begin
        m_sel = d[6];
        if (pwr) m_code = d[5:0];
      end
      host_u.read_reg(a, q);
      `CHK(q, (a == 8'h04) ? {1'b0, m_sel, m_code} : 8'h00)
      `CHK(code, want_scaled() ? scaled : m_code)
      `CHK(uses, want_scaled())
      `CHK(orng, rng)
    end
    // Mid-run reset with the enable low: reset must act regardless
    strap = 1'b1;
    @(posedge clk) #5;
    host_u.write_reg(8'h04, 8'h7f);
    rst    = 1'b1;
    clk_en = 1'b0;
    repeat (2) @(posedge clk);
    #5;
    `CHK(code, 6'h00)
    `CHK(uses, 1'b0)
    rst    = 1'b0;
    clk_en = 1'b1;
    host_u.read_reg(8'h04, q);
    `CHK(q, {2'b00, otp})
    give_verdict();
  end
endmodule : buck1_voltage_select_reg_tb_top

`default_nettype wire
